// ---- rtl/apu_map.vh ----
`ifndef APU_MAP_VH
`define APU_MAP_VH

// ==========================================
// Upload framing
`define APU_POS_W        32
`define APU_SUM_W        6
`define APU_POS_UNITS    5'h10
`define APU_LAST_UNIT    5'h12
`define APU_UNIT_W       5

// ==========================================
// Timing
`define APU_CLK_HZ       50000000
`define APU_TIMEOUT_S    5
`define APU_CNT_W        28

// ==========================================
// Absolute system selection codes
`define APU_SEL_INCR     2'h0
`define APU_SEL_ABS_DIO  2'h1

// ==========================================
// Register offsets
`define APU_REG_CTRL     2'h0
`define APU_REG_STATUS   2'h1
`define APU_REG_POS      2'h2
`define APU_REG_SUM      2'h3

// ==========================================
// Register fields and reset values
`define APU_CTRL_EN_BIT  0
`define APU_CTRL_RESET   1'h1
`define APU_ZERO32       32'h0000_0000

// ==========================================
// Upload state codes
`define APU_ST_IDLE      3'h0
`define APU_ST_PREP      3'h1
`define APU_ST_READY     3'h2
`define APU_ST_SEND      3'h3
`define APU_ST_FINISH    3'h4
`define APU_ST_ABORT     3'h5

`endif

// ---- rtl/apu_sync.v ----
// ==========================================
// Two-flop synchroniser for one pin
module apu_sync (
  // Clock and reset
  input  wire clk,
  input  wire rstn,
  // Pin side
  input  wire pinIn,
  // Synchronised level
  output wire syncOut
);

  reg meta_r;
  reg sync_r;

  // Only the second flop is ever read
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
    end
  end

  assign syncOut = sync_r;

endmodule // apu_sync

// ---- rtl/apu_upload.v ----
// Notes on behaviour
// - Upload mode reassigns three outputs to transfer
// - Low output carries unit bit zero
// - High output carries unit bit one
// - Ready low while preparing, high when done
// - Home set clears counter, stores home
// - Absolute system keeps both inputs repurposed
// - Outputs restored after upload completes
// - Absolute system: power stage turns on only in upload mode
// - Four-phase ready/request handshake per unit
// - Position sent as sixteen two-bit units
// - Checksum follows as three two-bit units
// - Correct completion asserts drive ready
// - Erase alarm at first power-up, sticky
// - Absolute selection effective after power cycle
// - Five second handshake timeout raises warning
// - Mode dropped mid-upload aborts with warning
// - Mode rising edge clears timeout warning
// - Checksum is six-bit sum of units
//
// The address-and-strobe port and the placing of the registers were decided locally.

`include "apu_map.vh"

module apu_upload #(
  parameter TIMEOUT_CYCLES = `APU_TIMEOUT_S * `APU_CLK_HZ
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Pins from the controller
  input  wire        positionUploadMode,
  input  wire        positionPairRequest,
  input  wire        homeSetClear,
  input  wire        servoOn,
  // Internal sources
  input  wire [31:0] absPosition,
  input  wire        positioningComplete,
  input  wire        zeroSpeedFlag,
  input  wire        torqueLimitActive,
  input  wire [1:0]  absSelectStored,
  input  wire        encoderNewlyConnected,
  // Output pins
  output reg         pin22Out_r,
  output reg         pin23Out_r,
  output reg         pin25Out_r,
  output reg         pin17Plain_r,
  output reg         pin18Plain_r,
  // Drive control
  output reg         powerStageEnable_r,
  output reg         driveReady_r,
  output reg         counterClear_r,
  output reg         backupWrite_r,
  output reg  [31:0] backupData_r,
  // Alarms
  output reg         transferTimeoutWarning_r,
  output reg         absEraseAlarm_r,
  // Register port
  input  wire [1:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata_r
);

  // ==========================================
  // Derived timing
  localparam integer          TO_LIMIT_I = TIMEOUT_CYCLES - 1;
  localparam [`APU_CNT_W-1:0] TO_LIMIT   = TO_LIMIT_I[`APU_CNT_W-1:0];

  // ==========================================
  // Pin synchronisers
  wire modeSync;
  wire reqSync;
  wire homeSync;
  wire servoSync;

  apu_sync uSyncMode (
    .clk     (clk),
    .rstn    (rstn),
    .pinIn   (positionUploadMode),
    .syncOut (modeSync)
  );

  apu_sync uSyncReq (
    .clk     (clk),
    .rstn    (rstn),
    .pinIn   (positionPairRequest),
    .syncOut (reqSync)
  );

  apu_sync uSyncHome (
    .clk     (clk),
    .rstn    (rstn),
    .pinIn   (homeSetClear),
    .syncOut (homeSync)
  );

  apu_sync uSyncServo (
    .clk     (clk),
    .rstn    (rstn),
    .pinIn   (servoOn),
    .syncOut (servoSync)
  );

  // ==========================================
  // Power-up capture
  // Selection and erase alarm are caught once after reset release,
  // so a later change of the stored selection waits for a power cycle.
  reg        captured_r;
  reg        absActive_r;
  reg        uploadEn_r;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      captured_r      <= 1'b0;
      absActive_r     <= 1'b0;
      absEraseAlarm_r <= 1'b0;
    end else if (!captured_r) begin
      captured_r      <= 1'b1;
      absActive_r     <= (absSelectStored == `APU_SEL_ABS_DIO);
      absEraseAlarm_r <= encoderNewlyConnected;
    end
  end

  // ==========================================
  // Edge detection on synchronised levels
  reg  modePrev_r;
  reg  homePrev_r;
  wire modeRise;
  wire homeRise;
  wire modeOn;

  // Input functions stay fixed for the whole power cycle
  assign modeOn   = absActive_r & modeSync;
  assign modeRise = modeOn & ~modePrev_r;
  assign homeRise = homeSync & ~homePrev_r;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modePrev_r <= 1'b0;
      homePrev_r <= 1'b0;
    end else begin
      modePrev_r <= modeOn;
      homePrev_r <= homeSync;
    end
  end

  // ==========================================
  // Upload state machine
  reg [2:0]            state_r;
  reg [2:0]            state_nxt;
  reg [`APU_UNIT_W-1:0] unit_r;
  reg [`APU_UNIT_W-1:0] unit_nxt;
  reg [31:0]           shift_r;
  reg [31:0]           shift_nxt;
  reg [31:0]           latchedPos_r;
  reg [`APU_SUM_W-1:0] sum_r;
  reg [`APU_SUM_W-1:0] sum_nxt;
  reg [`APU_SUM_W-1:0] lastSum_r;
  reg [1:0]            pair_r;
  reg [1:0]            pair_nxt;
  reg                  ready_r;
  reg                  ready_nxt;
  reg                  warnSet;
  reg                  done;
  reg [`APU_CNT_W-1:0] toCnt_r;
  wire                 timedOut;
  wire                 waiting;

  assign waiting  = (state_r == `APU_ST_READY) |
                    (state_r == `APU_ST_SEND)  |
                    (state_r == `APU_ST_FINISH);
  assign timedOut = waiting & (toCnt_r == TO_LIMIT);

  always @* begin
    state_nxt = state_r;
    unit_nxt  = unit_r;
    shift_nxt = shift_r;
    sum_nxt   = sum_r;
    pair_nxt  = pair_r;
    ready_nxt = ready_r;
    warnSet   = 1'b0;
    done      = 1'b0;
    case (state_r)
      `APU_ST_IDLE: begin
        ready_nxt = 1'b0;
        pair_nxt  = 2'b00;
        if (modeRise && uploadEn_r) begin
          state_nxt = `APU_ST_PREP;
          unit_nxt  = {`APU_UNIT_W{1'b0}};
          shift_nxt = absPosition;
          sum_nxt   = {`APU_SUM_W{1'b0}};
        end
      end
      `APU_ST_PREP: begin
        // Data latched, ready raised one cycle later
        state_nxt = `APU_ST_READY;
        ready_nxt = 1'b1;
      end
      `APU_ST_READY: begin
        if (reqSync) begin
          pair_nxt  = shift_r[1:0];
          shift_nxt = {2'b00, shift_r[31:2]};
          sum_nxt   = sum_r + {4'h0, shift_r[1:0]};
          ready_nxt = 1'b0;
          state_nxt = `APU_ST_SEND;
        end else if (timedOut) begin
          warnSet   = 1'b1;
          state_nxt = `APU_ST_ABORT;
        end
      end
      `APU_ST_SEND: begin
        if (!reqSync) begin
          ready_nxt = 1'b1;
          if (unit_r == `APU_LAST_UNIT) begin
            state_nxt = `APU_ST_FINISH;
          end else begin
            state_nxt = `APU_ST_READY;
          end
          unit_nxt = unit_r + 1'b1;
          if (unit_r == `APU_POS_UNITS - 1'b1) begin
            shift_nxt = {26'h0, sum_nxt};
          end
        end else if (timedOut) begin
          warnSet   = 1'b1;
          state_nxt = `APU_ST_ABORT;
        end
      end
      `APU_ST_FINISH: begin
        // Twentieth ready stays high until mode is released or the watchdog times out
        if (timedOut) begin
          warnSet   = 1'b1;
          state_nxt = `APU_ST_ABORT;
        end
      end
      `APU_ST_ABORT: begin
        ready_nxt = 1'b0;
      end
      default: begin
        state_nxt = `APU_ST_IDLE;
        ready_nxt = 1'b0;
      end
    endcase
    // Mode release ends any transfer; only a full one counts as done
    if (!modeOn && state_r != `APU_ST_IDLE) begin
      state_nxt = `APU_ST_IDLE;
      ready_nxt = 1'b0;
      if (state_r == `APU_ST_FINISH) begin
        done = 1'b1;
      end else if (state_r != `APU_ST_ABORT) begin
        warnSet = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r      <= `APU_ST_IDLE;
      unit_r       <= {`APU_UNIT_W{1'b0}};
      shift_r      <= `APU_ZERO32;
      sum_r        <= {`APU_SUM_W{1'b0}};
      pair_r       <= 2'b00;
      ready_r      <= 1'b0;
      latchedPos_r <= `APU_ZERO32;
      lastSum_r    <= {`APU_SUM_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      unit_r  <= unit_nxt;
      shift_r <= shift_nxt;
      sum_r   <= sum_nxt;
      pair_r  <= pair_nxt;
      ready_r <= ready_nxt;
      if (state_r == `APU_ST_IDLE && state_nxt == `APU_ST_PREP) begin
        latchedPos_r <= absPosition;
      end
      if (state_r == `APU_ST_SEND && unit_r == `APU_POS_UNITS - 1'b1
          && !reqSync) begin
        lastSum_r <= sum_nxt;
      end
    end
  end

  // ==========================================
  // Handshake watchdog, restarted on every ready edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      toCnt_r <= {`APU_CNT_W{1'b0}};
    end else if (!waiting || state_nxt != state_r) begin
      toCnt_r <= {`APU_CNT_W{1'b0}};
    end else if (!timedOut) begin
      toCnt_r <= toCnt_r + 1'b1;
    end
  end

  // ==========================================
  // Timeout warning
  // A mode rise and a new timeout cannot meet: a rise starts in idle.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      transferTimeoutWarning_r <= 1'b0;
    end else if (warnSet) begin
      transferTimeoutWarning_r <= 1'b1;
    end else if (modeRise) begin
      transferTimeoutWarning_r <= 1'b0;
    end
  end

  // ==========================================
  // Output allocation
  // Normal functions are followed live, so the restored pins show
  // the current state rather than a stale snapshot.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin22Out_r   <= 1'b0;
      pin23Out_r   <= 1'b0;
      pin25Out_r   <= 1'b0;
      pin17Plain_r <= 1'b0;
      pin18Plain_r <= 1'b0;
    end else if (modeOn) begin
      // Next pair, so the bits are valid in the cycle ready falls
      pin22Out_r <= pair_nxt[0] & ~ready_nxt;
      pin23Out_r <= pair_nxt[1] & ~ready_nxt;
      pin25Out_r <= ready_nxt;
    end else begin
      pin22Out_r   <= positioningComplete;
      pin23Out_r   <= zeroSpeedFlag;
      pin25Out_r   <= torqueLimitActive;
      pin17Plain_r <= ~absActive_r & modeSync;
      pin18Plain_r <= ~absActive_r & reqSync;
    end
  end

  // ==========================================
  // Power stage and drive ready
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      powerStageEnable_r <= 1'b0;
      driveReady_r       <= 1'b0;
    end else if (!servoSync) begin
      powerStageEnable_r <= 1'b0;
      driveReady_r       <= 1'b0;
    end else begin
      if (!absActive_r || modeOn) begin
        powerStageEnable_r <= 1'b1;
      end
      if (!absActive_r || done) begin
        driveReady_r <= 1'b1;
      end
    end
  end

  // ==========================================
  // Home position set
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      counterClear_r <= 1'b0;
      backupWrite_r  <= 1'b0;
      backupData_r   <= `APU_ZERO32;
    end else begin
      counterClear_r <= homeRise;
      backupWrite_r  <= homeRise;
      if (homeRise) begin
        backupData_r <= absPosition;
      end
    end
  end

  // ==========================================
  // Register port
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uploadEn_r <= `APU_CTRL_RESET;
    end else if (regWr && regAddr == `APU_REG_CTRL) begin
      uploadEn_r <= regWdata[`APU_CTRL_EN_BIT];
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata_r <= `APU_ZERO32;
    end else if (regRd) begin
      case (regAddr)
        `APU_REG_CTRL:   regRdata_r <= {31'h0, uploadEn_r};
        `APU_REG_STATUS: regRdata_r <= {16'h0, 3'h0, unit_r,
                                        state_r, absEraseAlarm_r,
                                        transferTimeoutWarning_r,
                                        driveReady_r, absActive_r,
                                        modeOn};
        `APU_REG_POS:    regRdata_r <= latchedPos_r;
        `APU_REG_SUM:    regRdata_r <= {26'h0, lastSum_r};
        default:         regRdata_r <= `APU_ZERO32;
      endcase
    end else begin
      regRdata_r <= `APU_ZERO32;
    end
  end

endmodule // apu_upload

// ---- verification/apu_ctrl_model.sv ----
module apu_ctrl_model (
  // Clock and commands
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [7:0]  slow,
  input  wire logic [4:0]  dropAt,
  // Device pins
  input  wire logic        lowBit,
  input  wire logic        highBit,
  input  wire logic        ready,
  output      logic        mode,
  output      logic        req,
  // Results
  output      logic        done,
  output      logic        ok,
  output      logic [31:0] rxPos,
  output      logic [5:0]  rxSum
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       err;
  logic [5:0] acc;
  logic [1:0] u;

  // Own watchdog: a stuck handshake ends the exchange
  task automatic waitFor(input logic lvl);
    int n;
    n = 0;
    while (ready !== lvl && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n == 200) err = 1;
  endtask

  initial begin
    {mode, req, done, ok, rxPos, rxSum} = '0;
    forever begin
      @(posedge clk);
      done <= 1'b0;
      if (start) begin
        err = 0;
        acc = 6'h00;
        mode <= 1'b1;
        // Pin 25 carries torque limit until the swap lands
        repeat (4) @(posedge clk);
        for (int i = 0; i < 19 && !err; i++) begin
          waitFor(1'b1);
          if (i == int'(dropAt)) err = 1;
          if (!err) begin
            repeat (slow) @(posedge clk);
            req <= 1'b1;
            waitFor(1'b0);
            u = {highBit, lowBit};
            if (i < 16) begin
              rxPos <= {u, rxPos[31:2]};
              acc = acc + {4'h0, u};
            end else begin
              rxSum <= {u, rxSum[5:2]};
            end
            req <= 1'b0;
          end
        end
        // Without an error, mode is dropped only after the twentieth ready
        if (!err) waitFor(1'b1);
        @(posedge clk);
        ok <= !err && rxSum == acc;
        mode <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule // apu_ctrl_model

// ---- verification/apu_upload_props.sv ----
module apu_upload_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins and sources
  input wire logic positionUploadMode,
  input wire logic positionPairRequest,
  input wire logic homeSetClear,
  input wire logic zeroSpeedFlag,
  // Watched outputs
  input wire logic pin22Out_r,
  input wire logic pin23Out_r,
  input wire logic pin25Out_r,
  input wire logic powerStageEnable_r,
  input wire logic driveReady_r,
  input wire logic counterClear_r,
  input wire logic backupWrite_r,
  input wire logic transferTimeoutWarning_r,
  input wire logic absEraseAlarm_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================
  // Sequences
  // Five cycles cover the pin synchroniser plus the output register
  sequence sModeLow;
    !positionUploadMode [*5];
  endsequence
  sequence sModeHigh;
    positionUploadMode [*5];
  endsequence

  // ==========================================
  // Properties
  chk_normal_alloc: assert property (
    sModeLow ##0 (zeroSpeedFlag == $past(zeroSpeedFlag))
    |-> pin23Out_r == zeroSpeedFlag) else $error("pin 23 not normal");
  chk_ready_data: assert property (
    sModeHigh ##0 pin25Out_r |-> !pin22Out_r && !pin23Out_r)
    else $error("data bits set while ready");
  chk_ready_fall: assert property (
    $fell(pin25Out_r) && positionUploadMode && $past(positionUploadMode, 4)
    |-> $past(positionPairRequest, 2) or ##[0:2] transferTimeoutWarning_r)
    else $error("ready fell without request");
  chk_ready_rise: assert property (
    $rose(pin25Out_r) && positionUploadMode && $past(positionUploadMode, 4)
    |-> !$past(positionPairRequest, 2)) else $error("ready rose early");
  chk_power_gate: assert property (
    $rose(powerStageEnable_r) |-> $past(positionUploadMode, 3))
    else $error("power stage on without upload mode");
  chk_home_set: assert property (
    $rose(homeSetClear) |-> ##[1:6] (counterClear_r && backupWrite_r))
    else $error("home set not acted on");
  chk_home_pulse: assert property (
    counterClear_r |=> !counterClear_r) else $error("clear pulse too long");
  chk_warn_clear: assert property (
    $rose(positionUploadMode) |-> ##[1:6] !transferTimeoutWarning_r)
    else $error("warning not cleared");
  chk_drive_ready: assert property (
    $rose(driveReady_r) |-> !positionUploadMode && !$past(positionUploadMode))
    else $error("drive ready during upload");
  chk_alarm_hold: assert property (
    absEraseAlarm_r |=> absEraseAlarm_r) else $error("alarm cleared");
endmodule // apu_upload_props

bind apu_upload apu_upload_props u_props (
  .clk(clk), .rstn(rstn), .positionUploadMode(positionUploadMode),
  .positionPairRequest(positionPairRequest), .homeSetClear(homeSetClear),
  .zeroSpeedFlag(zeroSpeedFlag), .pin22Out_r(pin22Out_r),
  .pin23Out_r(pin23Out_r), .pin25Out_r(pin25Out_r),
  .powerStageEnable_r(powerStageEnable_r), .driveReady_r(driveReady_r),
  .counterClear_r(counterClear_r), .backupWrite_r(backupWrite_r),
  .transferTimeoutWarning_r(transferTimeoutWarning_r),
  .absEraseAlarm_r(absEraseAlarm_r));

// ---- verification/apu_upload_tb.sv ----
module apu_upload_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rstn = 0, homeSet = 0, servoOn = 0, start = 0;
  logic        pc = 0, zs = 0, tl = 0, regWr = 0, regRd = 0, rdSeen = 0;
  logic [31:0] absPos = '0, regWdata = '0, rxPos, regRdata;
  logic [1:0]  regAddr = '0;
  logic [7:0]  slow = '0;
  logic [4:0]  dropAt = '0;
  logic [5:0]  rxSum;
  logic        mode, req, b0, b1, rdy, done, ok, pse, drv, warn, alarm;
  logic [31:0] backup;
  logic [38:0] expQ[$];
  logic [63:0] regQ[$];
  int          failCount = 0, checksDone = 0, cyc = 0;

  always #10 clk = ~clk;

  apu_upload #(.TIMEOUT_CYCLES(50)) dut_u (
    .clk(clk), .rstn(rstn), .positionUploadMode(mode),
    .positionPairRequest(req), .homeSetClear(homeSet), .servoOn(servoOn),
    .absPosition(absPos), .positioningComplete(pc), .zeroSpeedFlag(zs),
    .torqueLimitActive(tl), .absSelectStored(2'h1),
    .encoderNewlyConnected(1'b1), .pin22Out_r(b0), .pin23Out_r(b1),
    .pin25Out_r(rdy), .pin17Plain_r(), .pin18Plain_r(),
    .powerStageEnable_r(pse), .driveReady_r(drv), .counterClear_r(),
    .backupWrite_r(), .backupData_r(backup),
    .transferTimeoutWarning_r(warn), .absEraseAlarm_r(alarm),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata_r(regRdata));

  apu_ctrl_model plc_u (
    .clk(clk), .start(start), .slow(slow), .dropAt(dropAt), .lowBit(b0),
    .highBit(b1), .ready(rdy), .mode(mode), .req(req), .done(done),
    .ok(ok), .rxPos(rxPos), .rxSum(rxSum));

  // ==========================================
  // Compare and report
  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    checksDone++;
    if (act !== exp) begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic flag(input logic act, input logic exp);
    check({31'h0, act}, {31'h0, exp});
  endtask
  task final_report;
    $display("Checks %0d errors %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [5:0] sum6(input logic [31:0] p);
    sum6 = 6'h00;
    for (int i = 0; i < 16; i++) sum6 = sum6 + {4'h0, p[2*i +: 2]};
  endfunction

  // ==========================================
  // Result watcher
  always @(posedge clk) begin
    logic [38:0] e;
    logic [63:0] r;
    cyc <= cyc + 1;
    rdSeen <= regRd;
    if (rdSeen) begin
      r = regQ.pop_front();
      check(regRdata & r[63:32], r[31:0]);
    end
    if (done) begin
      e = expQ.pop_front();
      flag(ok, e[38]);
      if (e[38]) check(rxPos, e[31:0]);
      if (e[38]) check({26'h0, rxSum}, {26'h0, e[37:32]});
    end
    if (cyc == 30000) begin
      failCount++;
      final_report();
    end
  end

  // ==========================================
  // Stimulus
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      pc <= 1'($urandom);
      zs <= 1'($urandom);
      tl <= 1'($urandom);
    end
  endtask
  task automatic regAccess(input logic [1:0] a, input logic wr,
                           input logic [31:0] d, input logic [31:0] m);
    regAddr <= a;
    regWdata <= d;
    if (!wr) regQ.push_back({m, d & m});
    if (wr) regWr <= 1'b1;
    else regRd <= 1'b1;
    tick(1);
    {regWr, regRd} <= 2'b00;
    tick(1);
  endtask
  task automatic upload(input logic [31:0] p, input logic [7:0] s,
                        input logic [4:0] d, input logic okExp);
    int n;
    absPos <= p;
    slow <= s;
    dropAt <= d;
    expQ.push_back({okExp, sum6(p), p});
    start <= 1'b1;
    tick(1);
    start <= 1'b0;
    tick(8);
    servoOn <= 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    if (n == 5000) failCount++;
    tick(6);
    flag(warn, !okExp);
    if (okExp) flag(pse, 1'b1);
    if (okExp) flag(drv, 1'b1);
    if (okExp) regAccess(2'h3, 1'b0, {26'h0, sum6(p)}, 32'h0000_003f);
    servoOn <= 1'b0;
    tick(6);
  endtask

  initial begin
    void'($urandom(79228));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    tick(2);
    flag(alarm, 1'b1);
    regAccess(2'h0, 1'b1, 32'h0000_0000, 32'h0);
    regAccess(2'h0, 1'b0, 32'h0000_0000, 32'h0000_0001);
    regAccess(2'h0, 1'b1, 32'h0000_0001, 32'h0);
    regAccess(2'h0, 1'b0, 32'h0000_0001, 32'h0000_0001);
    servoOn <= 1'b1;
    tick(20);
    flag(pse, 1'b0);
    upload(32'hFFFF_FFF6, 8'h00, 5'h1f, 1'b1);
    regAccess(2'h2, 1'b0, 32'hFFFF_FFF6, 32'hFFFF_FFFF);
    upload($urandom, 8'h0a, 5'h1f, 1'b1);
    upload($urandom, 8'h50, 5'h1f, 1'b0);
    upload($urandom, 8'h00, 5'h05, 1'b0);
    upload($urandom, 8'h03, 5'h1f, 1'b1);
    homeSet <= 1'b1;
    tick(8);
    homeSet <= 1'b0;
    check(backup, absPos);
    tick(10);
    final_report();
  end
endmodule // apu_upload_tb
